// ---- fpsc_pkg.sv ----
package fpsc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_FLASH_STATUS_REG  = 8'h00;
    localparam logic [7:0] A_PSTAT  = 8'h04;
    localparam logic [7:0] A_FCFG   = 8'h08;
    localparam logic [7:0] A_ECFG   = 8'h0C;
    localparam logic [7:0] A_ESTAT  = 8'h10;
    localparam logic [7:0] A_PPROT  = 8'h14;
    localparam logic [7:0] A_DPROT  = 8'h18;
    localparam logic [7:0] A_PAR0   = 8'h1C;
    localparam logic [7:0] A_PAR1   = 8'h20;
    localparam logic [7:0] A_BDK01  = 8'h24;
    localparam logic [7:0] A_BDK23  = 8'h28;
    localparam logic [7:0] A_LAUNCH = 8'h2C;
    localparam logic [7:0] A_SEC    = 8'h30;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int          B_CMD_COMPLETE_FLAG     = 0;
    localparam int          B_ACCESS_ERROR_FLAG   = 1;
    localparam int          B_OP_BD    = 4;
    localparam logic [1:0]  SEC_UNSEC  = 2'h2;
    localparam logic [1:0]  BACKDOOR_KEY_ENABLE_ON   = 2'h2;
    localparam logic [15:0] KEY_ONES   = 16'hFFFF;
    localparam logic [15:0] KEY_ZERO   = 16'h0000;
    localparam logic [23:0] SEC_BYTE_GADDR = 24'hFF_FE0F;
    localparam logic [7:0]  PROT_RST   = 8'h00;
    localparam logic [2:0]  IDX_ONE    = 3'h1;
    localparam logic [2:0]  IDX_TWO    = 3'h2;
    localparam logic [2:0]  IDX_THREE  = 3'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CMD_TIME_NS   = 200;
    localparam int CMD_CYCLES    = (CMD_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : CMD_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } fpsc_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } fpsc_aphase_t;

endpackage : fpsc_pkg

// ---- fpsc_top.sv ----
// Functional notes
// - each override launch with a matching key saves both protection registers in one save slot
// - restore reloads both registers from last saved pair, dropping software writes
// - restore uses saved values only, never reset defaults
// - access error, no run, if override index is not 001, 010 or 011
// - access error if command unavailable in current mode or security
// - access error if restore requested while override bit is clear
// - access error if selection 00 with index 010 or 011
// - access error if selection 00, index 001 and key valid
// - command interrupt while complete flag and its enable are set
// - error interrupt while single fault flag and its enable are set
// - stop request is held off until active command finishes
// - security register loads from configuration security byte in first cycle after reset (reset loads 00)
// - reprogrammed security byte only takes effect at next reset
// - backdoor compares four 16-bit words, only when key enable is on
// - backdoor match forces security field to unsecured 10
// - stored backdoor keys 0000 or FFFF never unlock
// - reads return invalid data while backdoor verify is running
// - after an illegal key, backdoor verify refused until reset
// - backdoor verify leaves security byte, keys and protection unchanged
// - successful override sets override active bit
// - all-ones or mismatching key restores both registers, clears override bit
// - command complete flag sets when command finishes
module fpsc_top #(
    parameter int CMD_CYC = fpsc_pkg::CMD_CYCLES
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // configuration field and mode
    input  wire logic [7:0]  cfg_security_byte,
    input  wire logic [15:0] cfg_override_key,
    input  wire logic [63:0] cfg_backdoor_keys,
    input  wire logic        cmd_available,
    // system events
    input  wire logic        ecc_single_fault,
    input  wire logic        stop_req,
    // outputs to system
    output logic             cmd_irq,
    output logic             err_irq,
    output logic             stop_ack,
    output logic             read_invalid,
    output logic [1:0]       security_field
);

    // elaboration check: the busy counter is eight bits wide,
    // so the check accepts counts 1..255 only
    if (CMD_CYC < 1 || CMD_CYC > 255) begin : g_cyc_check
        $error("CMD_CYC out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fpsc_pkg::fpsc_state_t state_reg;
    fpsc_pkg::fpsc_aphase_t ap_reg;
    logic [7:0]  cnt_reg;
    logic        access_error_flag_reg;
    logic        ovr_reg;
    logic        cie_reg;
    logic        sfie_reg;
    logic        single_fault_flag_reg;
    logic [7:0]  pprot_reg;
    logic [7:0]  dprot_reg;
    logic [7:0]  save_p_reg;
    logic [7:0]  save_d_reg;
    logic [31:0] par0_reg;
    logic [31:0] par1_reg;
    logic [63:0] bdk_reg;
    logic [7:0]  security_reg;
    logic        bd_lock_reg;
    logic        op_bd_reg;
    logic        match_reg;
    logic [1:0]  sel_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic        cmd_complete_flag;
    logic        wr_dp;
    logic        launch;
    logic        l_bd;
    logic [2:0]  l_idx;
    logic [15:0] key;
    logic        k_inv;
    logic        k_match;
    logic        ovr_err;
    logic        bd_err;
    logic        done;
    logic [3:0]  wmatch;
    logic        bd_ok;

    assign cmd_complete_flag    = (state_reg == fpsc_pkg::ST_IDLE);
    assign wr_dp   = ap_reg.wr;
    assign launch  = wr_dp && ap_reg.addr == fpsc_pkg::A_LAUNCH && cmd_complete_flag;
    assign l_idx   = hwdata[2:0];
    assign l_bd    = hwdata[fpsc_pkg::B_OP_BD];
    assign key     = par0_reg[31:16];
    assign k_inv   = (key == fpsc_pkg::KEY_ONES);
    assign k_match = !k_inv && cfg_override_key != fpsc_pkg::KEY_ONES && key == cfg_override_key;
    assign ovr_err = !(l_idx == fpsc_pkg::IDX_ONE || l_idx == fpsc_pkg::IDX_TWO
                       || l_idx == fpsc_pkg::IDX_THREE)
                     || !cmd_available
                     || (!k_match && !ovr_reg)
                     || (par0_reg[1:0] == 2'h0 && l_idx != fpsc_pkg::IDX_ONE)
                     || (par0_reg[1:0] == 2'h0 && l_idx == fpsc_pkg::IDX_ONE && !k_inv);
    assign bd_err  = bd_lock_reg || !cmd_available
                     || security_reg[7:6] != fpsc_pkg::BACKDOOR_KEY_ENABLE_ON;
    assign done    = state_reg == fpsc_pkg::ST_BUSY && cnt_reg == 8'(CMD_CYC - 1);

    // per-word backdoor compare; forbidden stored values never match
    generate
        for (genvar g = 0; g < 4; g++) begin : g_key
            assign wmatch[g] = bdk_reg[16*g +: 16] == cfg_backdoor_keys[16*g +: 16]
                               && cfg_backdoor_keys[16*g +: 16] != fpsc_pkg::KEY_ZERO
                               && cfg_backdoor_keys[16*g +: 16] != fpsc_pkg::KEY_ONES;
        end
    endgenerate
    assign bd_ok = &wmatch;

    // ------------------------------------------------------------
    // ahb address phase capture
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_reg <= '0;
        end else begin
            ap_reg.wr   <= hsel && hready && htrans[1] && hwrite;
            ap_reg.rd   <= hsel && hready && htrans[1] && !hwrite;
            ap_reg.addr <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= fpsc_pkg::ST_INIT;
            cnt_reg   <= 8'h00;
        end else begin
            case (state_reg)
                fpsc_pkg::ST_INIT: state_reg <= fpsc_pkg::ST_IDLE;
                fpsc_pkg::ST_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (launch && !(l_bd ? bd_err : ovr_err)) begin
                        state_reg <= fpsc_pkg::ST_BUSY;
                    end
                end
                fpsc_pkg::ST_BUSY: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (done) begin
                        state_reg <= fpsc_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= fpsc_pkg::ST_IDLE;
            endcase
        end
    end

    // latched command choice at launch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_bd_reg <= 1'b0;
            match_reg <= 1'b0;
            sel_reg   <= 2'h0;
        end else if (launch) begin
            op_bd_reg <= l_bd;
            match_reg <= k_match;
            sel_reg   <= par0_reg[1:0];
        end
    end

    // access error: set on bad launch or illegal key, write one to clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            access_error_flag_reg <= 1'b0;
        end else if (launch && (l_bd ? bd_err : ovr_err)) begin
            access_error_flag_reg <= 1'b1;
        end else if (done && op_bd_reg && !bd_ok) begin
            access_error_flag_reg <= 1'b1;
        end else if (wr_dp && ap_reg.addr == fpsc_pkg::A_FLASH_STATUS_REG && hwdata[fpsc_pkg::B_ACCESS_ERROR_FLAG]) begin
            access_error_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // protection registers, save slot, override bit
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pprot_reg  <= fpsc_pkg::PROT_RST;
            dprot_reg  <= fpsc_pkg::PROT_RST;
            save_p_reg <= fpsc_pkg::PROT_RST;
            save_d_reg <= fpsc_pkg::PROT_RST;
            ovr_reg    <= 1'b0;
        end else if (done && !op_bd_reg) begin
            if (match_reg) begin
                save_p_reg <= pprot_reg;
                save_d_reg <= dprot_reg;
                ovr_reg    <= 1'b1;
                if (sel_reg[0]) begin
                    pprot_reg <= par1_reg[7:0];
                end
                if (sel_reg[1]) begin
                    dprot_reg <= par1_reg[15:8];
                end
            end else begin
                pprot_reg <= save_p_reg;
                dprot_reg <= save_d_reg;
                ovr_reg   <= 1'b0;
            end
        end else if (wr_dp && ap_reg.addr == fpsc_pkg::A_PPROT) begin
            pprot_reg <= hwdata[7:0];
        end else if (wr_dp && ap_reg.addr == fpsc_pkg::A_DPROT) begin
            dprot_reg <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // software parameter and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            par0_reg <= 32'h0000_0000;
            par1_reg <= 32'h0000_0000;
            bdk_reg  <= '0;
            cie_reg  <= 1'b0;
            sfie_reg <= 1'b0;
        end else if (wr_dp) begin
            case (ap_reg.addr)
                fpsc_pkg::A_PAR0:  par0_reg <= hwdata;
                fpsc_pkg::A_PAR1:  par1_reg <= hwdata;
                fpsc_pkg::A_BDK01: bdk_reg[31:0] <= hwdata;
                fpsc_pkg::A_BDK23: bdk_reg[63:32] <= hwdata;
                fpsc_pkg::A_FCFG:  cie_reg <= hwdata[0];
                fpsc_pkg::A_ECFG:  sfie_reg <= hwdata[0];
                default: ;
            endcase
        end
    end

    // single fault flag: a new fault wins over a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            single_fault_flag_reg <= 1'b0;
        end else if (ecc_single_fault) begin
            single_fault_flag_reg <= 1'b1;
        end else if (wr_dp && ap_reg.addr == fpsc_pkg::A_ESTAT && hwdata[0]) begin
            single_fault_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // security
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            security_reg <= 8'h00;
            bd_lock_reg  <= 1'b0;
        end else if (state_reg == fpsc_pkg::ST_INIT) begin
            security_reg <= cfg_security_byte;
        end else if (done && op_bd_reg) begin
            if (bd_ok) begin
                security_reg[1:0] <= fpsc_pkg::SEC_UNSEC;
            end else begin
                bd_lock_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_irq        <= 1'b0;
            err_irq        <= 1'b0;
            stop_ack       <= 1'b0;
            read_invalid   <= 1'b0;
            security_field <= 2'h0;
        end else begin
            cmd_irq        <= cmd_complete_flag && cie_reg;
            err_irq        <= single_fault_flag_reg && sfie_reg;
            stop_ack       <= stop_req && cmd_complete_flag;
            read_invalid   <= state_reg == fpsc_pkg::ST_BUSY && op_bd_reg && !done;
            security_field <= security_reg[1:0];
        end
    end

    // ahb read data, zero-wait, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    fpsc_pkg::A_FLASH_STATUS_REG: hrdata <= {30'h0, access_error_flag_reg, cmd_complete_flag};
                    fpsc_pkg::A_PSTAT: hrdata <= {31'h0, ovr_reg};
                    fpsc_pkg::A_FCFG:  hrdata <= {31'h0, cie_reg};
                    fpsc_pkg::A_ECFG:  hrdata <= {31'h0, sfie_reg};
                    fpsc_pkg::A_ESTAT: hrdata <= {31'h0, single_fault_flag_reg};
                    fpsc_pkg::A_PPROT: hrdata <= {24'h0, pprot_reg};
                    fpsc_pkg::A_DPROT: hrdata <= {24'h0, dprot_reg};
                    fpsc_pkg::A_PAR0:  hrdata <= par0_reg;
                    fpsc_pkg::A_PAR1:  hrdata <= par1_reg;
                    fpsc_pkg::A_SEC:   hrdata <= {23'h0, bd_lock_reg, security_reg};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_save_slot: assert property (done && !op_bd_reg && match_reg |=>
        save_p_reg == $past(pprot_reg) && save_d_reg == $past(dprot_reg) && ovr_reg)
        else $error("save slot not loaded");
    a_restore_load: assert property (done && !op_bd_reg && !match_reg |=>
        pprot_reg == $past(save_p_reg) && dprot_reg == $past(save_d_reg) && !ovr_reg)
        else $error("restore did not load saved pair");
    a_bad_index: assert property (launch && !l_bd && l_idx == 3'h0 |=>
        access_error_flag_reg && state_reg == fpsc_pkg::ST_IDLE)
        else $error("bad index not refused");
    a_not_avail: assert property (launch && !cmd_available |=> access_error_flag_reg && cmd_complete_flag)
        else $error("unavailable command ran");
    a_no_saved: assert property (launch && !l_bd && !k_match && !ovr_reg |=> access_error_flag_reg)
        else $error("restore without saved values");
    a_cmd_irq: assert property (cmd_complete_flag && cie_reg |=> cmd_irq)
        else $error("command irq missing");
    a_err_irq: assert property (!(single_fault_flag_reg && sfie_reg) |=> !err_irq)
        else $error("error irq without cause");
    a_stop_hold: assert property (stop_req && state_reg == fpsc_pkg::ST_BUSY |=> !stop_ack)
        else $error("stop allowed while busy");
    a_bd_unsec: assert property (done && op_bd_reg && bd_ok |=>
        security_reg[1:0] == fpsc_pkg::SEC_UNSEC ##1 security_field == fpsc_pkg::SEC_UNSEC)
        else $error("backdoor match did not unsecure");
    a_bd_lock: assert property (bd_lock_reg && launch && l_bd |=> access_error_flag_reg ##0 cmd_complete_flag)
        else $error("locked backdoor ran");
    a_done_flag: assert property (launch && !l_bd && !ovr_err |=> !cmd_complete_flag [*3] ##[1:300] cmd_complete_flag)
        else $error("command did not complete");

    c_override: cover property (done && !op_bd_reg && match_reg);
    c_restore:  cover property (done && !op_bd_reg && !match_reg);
    c_unlock:   cover property (done && op_bd_reg && bd_ok);
    c_stop:     cover property (stop_req && !cmd_complete_flag ##[1:20] stop_ack);

endmodule : fpsc_top

// ---- fpsc_cpu_model.sv ----
module fpsc_cpu_model (
    // clock and answer
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // master request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    // read results
    output logic [31:0]      rd_data,
    output logic             rd_tog
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
        rd_data = 32'h0000_0000;
        rd_tog = 1'b0;
    end

    // --------------------------------------------------------
    // single word transfer, released lines show a changed value
    // --------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        hwdata <= ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~haddr;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        if (!w) begin
            rd_data <= hrdata;
            rd_tog  <= ~rd_tog;
        end
    endtask : xfer
endmodule : fpsc_cpu_model

// ---- tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CYC = 5;
    localparam logic [2:0] E_IDX [7] = '{3'h0, 3'h4, 3'h3, 3'h1, 3'h2, 3'h3, 3'h1};
    localparam logic [1:0] E_SEL [7] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
    localparam logic       E_ONE [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    localparam logic       E_AVL [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp, rd_tog;
    logic [31:0] haddr, hwdata, hrdata, rd_data;
    logic [1:0]  htrans, security_field;
    logic [2:0]  hsize;
    logic [7:0]  cfg_security_byte = 8'h83;
    logic [15:0] okey;
    logic [63:0] skeys;
    logic        cmd_available = 1'b1;
    logic        ecc_single_fault = 1'b0;
    logic        stop_req = 1'b0;
    logic        cmd_irq, err_irq, stop_ack, read_invalid;
    logic [7:0]  pa, pb, n1, n2, m1;
    logic [31:0] exp_q[$];
    int          fail_count = 0;
    int          comparisons = 0;

    always #20 hclk = ~hclk;

    fpsc_cpu_model i_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_data(rd_data), .rd_tog(rd_tog));

    fpsc_top #(.CMD_CYC(CYC)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg_security_byte(cfg_security_byte),
        .cfg_override_key(okey), .cfg_backdoor_keys(skeys), .cmd_available(cmd_available),
        .ecc_single_fault(ecc_single_fault), .stop_req(stop_req), .cmd_irq(cmd_irq), .err_irq(err_irq),
        .stop_ack(stop_ack), .read_invalid(read_invalid), .security_field(security_field));

    // --------------------------------------------------------
    // compare, bus and command helpers
    // --------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    always @(rd_tog) if (exp_q.size() > 0) chk(rd_data, exp_q.pop_front());

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_cpu.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_cpu.xfer(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic bk(input logic [63:0] k);
        wr(fpsc_pkg::A_BDK01, k[31:0]);
        wr(fpsc_pkg::A_BDK23, k[63:32]);
    endtask : bk

    task automatic launch(input logic [2:0] idx, input logic bd, input logic busy);
        wr(fpsc_pkg::A_LAUNCH, {27'h000_0000, bd, 1'b0, idx});
        repeat (2) @(posedge hclk);
        #1;
        if (busy) chk({read_invalid, stop_ack, cmd_irq}, {bd, 2'h0});
        repeat (CYC) @(posedge hclk);
        #1;
        chk({hresp, hreadyout, read_invalid, stop_ack}, 4'h5);
    endtask : launch

    task automatic do_reset(input logic [7:0] sb, input logic [63:0] k);
        hresetn <= 1'b0;
        cfg_security_byte <= sb;
        skeys <= k;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        #1;
    endtask : do_reset

    task automatic tdone(input string name);
        $display("test %0s done at %0t", name, $time);
    endtask : tdone

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    initial begin
        #(40 * 20000);
        fail_count++;
        results();
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        void'($urandom(22));
        okey = 16'($urandom_range(16'hFFFE, 16'h0001));
        for (int i = 0; i < 4; i++) skeys[16*i +: 16] = 16'($urandom_range(16'hFFFE, 16'h0001));
        {pa, pb, n1, n2} = $urandom | 32'h0101_0101;
        m1 = ~n1;
        do_reset(8'h83, skeys);
        stop_req <= 1'b1;
        rd(fpsc_pkg::A_PPROT, 32'h0000_0000);
        wr(fpsc_pkg::A_FCFG, 32'h0000_0001);
        wr(fpsc_pkg::A_PPROT, {24'h00_0000, pa});
        wr(fpsc_pkg::A_DPROT, {24'h00_0000, pb});
        for (int i = 0; i < 7; i++) begin
            cmd_available <= E_AVL[i];
            wr(fpsc_pkg::A_PAR0, {(E_ONE[i] ? fpsc_pkg::KEY_ONES : okey), 14'h0000, E_SEL[i]});
            launch(E_IDX[i], 1'b0, 1'b0);
            rd(fpsc_pkg::A_FLASH_STATUS_REG, 32'h0000_0003);
            wr(fpsc_pkg::A_FLASH_STATUS_REG, 32'h0000_0002);
        end
        cmd_available <= 1'b1;
        rd(fpsc_pkg::A_PPROT, {24'h00_0000, pa});
        tdone("override errors");
        wr(fpsc_pkg::A_PAR1, {16'h0000, n2, n1});
        wr(fpsc_pkg::A_PAR0, {okey, 16'h0003});
        launch(3'h3, 1'b0, 1'b1);
        chk(cmd_irq, 1'b1);
        rd(fpsc_pkg::A_PPROT, {24'h00_0000, n1});
        rd(fpsc_pkg::A_DPROT, {24'h00_0000, n2});
        rd(fpsc_pkg::A_PSTAT, 32'h0000_0001);
        wr(fpsc_pkg::A_PAR1, {24'h00_0000, m1});
        wr(fpsc_pkg::A_PAR0, {okey, 16'h0001});
        launch(3'h3, 1'b0, 1'b0);
        rd(fpsc_pkg::A_PPROT, {24'h00_0000, m1});
        wr(fpsc_pkg::A_PPROT, {24'h00_0000, pa});
        wr(fpsc_pkg::A_PAR0, {fpsc_pkg::KEY_ONES, 16'h0000});
        launch(3'h1, 1'b0, 1'b0);
        rd(fpsc_pkg::A_PPROT, {24'h00_0000, n1});
        rd(fpsc_pkg::A_DPROT, {24'h00_0000, n2});
        rd(fpsc_pkg::A_PSTAT, 32'h0000_0000);
        tdone("override restore");
        wr(fpsc_pkg::A_ECFG, 32'h0000_0001);
        ecc_single_fault <= 1'b1;
        @(posedge hclk) ecc_single_fault <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        chk(err_irq, 1'b1);
        rd(fpsc_pkg::A_ESTAT, 32'h0000_0001);
        wr(fpsc_pkg::A_ESTAT, 32'h0000_0001);
        wr(fpsc_pkg::A_FCFG, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        #1;
        chk({err_irq, cmd_irq}, 2'h0);
        tdone("interrupts");
        do_reset(8'h83, skeys);
        chk(security_field, 2'h3);
        rd(fpsc_pkg::A_SEC, 32'h0000_0083);
        cfg_security_byte <= 8'h81;
        bk(skeys ^ 64'h1);
        launch(3'h0, 1'b1, 1'b0);
        rd(fpsc_pkg::A_FLASH_STATUS_REG, 32'h0000_0003);
        rd(fpsc_pkg::A_SEC, 32'h0000_0183);
        wr(fpsc_pkg::A_FLASH_STATUS_REG, 32'h0000_0002);
        bk(skeys);
        launch(3'h0, 1'b1, 1'b0);
        rd(fpsc_pkg::A_FLASH_STATUS_REG, 32'h0000_0003);
        chk(security_field, 2'h3);
        do_reset(8'h81, skeys);
        chk(security_field, 2'h1);
        bk(skeys);
        launch(3'h0, 1'b1, 1'b1);
        chk(security_field, fpsc_pkg::SEC_UNSEC);
        rd(fpsc_pkg::A_SEC, 32'h0000_0082);
        rd(fpsc_pkg::A_PPROT, 32'h0000_0000);
        do_reset(8'h43, skeys);
        bk(skeys);
        launch(3'h0, 1'b1, 1'b0);
        rd(fpsc_pkg::A_FLASH_STATUS_REG, 32'h0000_0003);
        chk(security_field, 2'h3);
        do_reset(8'h83, {skeys[63:48], fpsc_pkg::KEY_ZERO, skeys[31:0]});
        bk({skeys[63:48], fpsc_pkg::KEY_ZERO, skeys[31:0]});
        launch(3'h0, 1'b1, 1'b0);
        rd(fpsc_pkg::A_FLASH_STATUS_REG, 32'h0000_0003);
        chk(security_field, 2'h3);
        tdone("security");
        results();
    end
endmodule : tb
